// ---- fbasa_pkg.sv ----
// Purpose: Shared constants for the four-bit ALU and shift accumulator slice
// Assumes: Register select vector bit 0 is the first select pin, bit 1 the second
// Notes: Codes follow the select pin levels directly
package fbasa_pkg;
    localparam int unsigned FBASA_WIDTH = 4;
    localparam int unsigned FBASA_FSEL_WIDTH = 3;
    localparam int unsigned FBASA_SYNC_WIDTH = 14;
    localparam logic [1:0] FBASA_RSEL_LOAD = 2'h0;
    localparam logic [1:0] FBASA_RSEL_LEFT = 2'h2;
    localparam logic [1:0] FBASA_RSEL_RIGHT = 2'h1;
    localparam logic [1:0] FBASA_RSEL_HOLD = 2'h3;
    localparam logic [2:0] FBASA_FN_ALL_ONES = 3'h0;
    localparam logic [2:0] FBASA_FN_B_MINUS_A = 3'h1;
    localparam logic [2:0] FBASA_FN_A_MINUS_B = 3'h2;
    localparam logic [2:0] FBASA_FN_A_PLUS_B = 3'h3;
    localparam logic [2:0] FBASA_FN_PASS_B = 3'h4;
    localparam logic [2:0] FBASA_FN_NOT_B = 3'h5;
    localparam logic [2:0] FBASA_FN_PASS_A = 3'h6;
    localparam logic [2:0] FBASA_FN_NOT_A = 3'h7;
    localparam logic [2:0] FBASA_LG_ZERO = 3'h0;
    localparam logic [2:0] FBASA_LG_XOR_A = 3'h1;
    localparam logic [2:0] FBASA_LG_XOR_B = 3'h2;
    localparam logic [2:0] FBASA_LG_AND_A = 3'h3;
    localparam logic [2:0] FBASA_LG_AND_B = 3'h4;
    localparam logic [2:0] FBASA_LG_OR_A = 3'h5;
    localparam logic [2:0] FBASA_LG_NAND = 3'h6;
    localparam logic [2:0] FBASA_LG_OR_B = 3'h7;
    localparam logic [3:0] FBASA_OUT_RST = 4'h0;
    localparam logic FBASA_BIT_RST = 1'b0;
    localparam logic FBASA_NBIT_RST = 1'b1;
    localparam logic [13:0] FBASA_SYNC_RST = 14'h0000;
endpackage

// ---- fbasa_alu_if.sv ----
// Purpose: Carries operands, selects and results between the slice and its ALU
// Assumes: Purely combinational ALU behind the alu modport
// Notes: None
`timescale 1ns/1ps
interface fbasa_alu_if;
    logic [3:0] operand_a;
    logic [3:0] operand_b;
    logic [2:0] func_sel;
    logic logic_mode;
    logic carry_in;
    logic [3:0] result;
    logic carry_out;
    logic prop_n;
    logic gen_n;
    modport alu (input operand_a, operand_b, func_sel, logic_mode, carry_in,
        output result, carry_out, prop_n, gen_n);
    modport user (output operand_a, operand_b, func_sel, logic_mode, carry_in,
        input result, carry_out, prop_n, gen_n);
endinterface

// ---- fbasa_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to mclk_in
// Notes: A new level is taken only once stages two and three agree
`timescale 1ns/1ps
module fbasa_sync
    import fbasa_pkg::*;
#(
    parameter int unsigned WIDTH = FBASA_SYNC_WIDTH
)
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] pins_in,
    output logic [WIDTH-1:0] level_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic lvl;
            logic next_lvl;
            always_comb
            begin
                next_lvl = (s2 == s3) ? s3 : lvl;
            end
            always_ff @(posedge mclk_in)
            begin
                if (!resetn_in)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    lvl <= 1'b0;
                end
                else
                begin
                    s1 <= pins_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    lvl <= next_lvl;
                end
            end
            assign level_out[i] = lvl;
        end
    endgenerate
endmodule

// ---- fbasa_alu.sv ----
// Purpose: Four-bit function generator with full internal look-ahead
// Assumes: Operand B comes from the storage register
// Notes: Arithmetic is a sum of two chosen words plus a carry
`timescale 1ns/1ps
module fbasa_alu
    import fbasa_pkg::*;
(
    fbasa_alu_if.alu bus
);
    logic [3:0] x;
    logic [3:0] y;
    logic c0;
    logic [3:0] p;
    logic [3:0] g;
    logic [4:0] c;
    logic [3:0] lg;
    always_comb
    begin
        x = bus.operand_a;
        y = bus.operand_b;
        c0 = bus.carry_in;
        unique case (bus.func_sel)
            // All ones plus an inverted carry gives the 1110 / 1111 pair
            FBASA_FN_ALL_ONES:
            begin
                x = 4'hf;
                y = 4'hf;
                c0 = ~bus.carry_in;
            end
            FBASA_FN_B_MINUS_A: x = ~bus.operand_a;
            FBASA_FN_A_MINUS_B: y = ~bus.operand_b;
            FBASA_FN_A_PLUS_B: x = bus.operand_a;
            FBASA_FN_PASS_B: x = 4'h0;
            FBASA_FN_NOT_B:
            begin
                x = 4'h0;
                y = ~bus.operand_b;
            end
            FBASA_FN_PASS_A: y = 4'h0;
            FBASA_FN_NOT_A:
            begin
                x = ~bus.operand_a;
                y = 4'h0;
            end
        endcase
        p = x | y;
        g = x & y;
        // Carries formed in parallel, not rippled
        c[0] = c0;
        c[1] = g[0] | (p[0] & c0);
        c[2] = g[1] | (p[1] & g[0]) | (p[1] & p[0] & c0);
        c[3] = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) | (p[2] & p[1] & p[0] & c0);
        c[4] = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0])
            | (p[3] & p[2] & p[1] & p[0] & c0);
        unique case (bus.func_sel)
            FBASA_LG_ZERO: lg = 4'h0;
            FBASA_LG_XOR_A: lg = bus.operand_a ^ bus.operand_b;
            FBASA_LG_XOR_B: lg = bus.operand_a ^ bus.operand_b;
            FBASA_LG_AND_A: lg = bus.operand_a & bus.operand_b;
            FBASA_LG_AND_B: lg = bus.operand_a & bus.operand_b;
            FBASA_LG_OR_A: lg = bus.operand_a | bus.operand_b;
            FBASA_LG_NAND: lg = ~(bus.operand_a & bus.operand_b);
            FBASA_LG_OR_B: lg = bus.operand_a | bus.operand_b;
        endcase
        if (bus.logic_mode)
        begin
            bus.result = lg;
            bus.carry_out = 1'b0;
            bus.prop_n = 1'b1;
            bus.gen_n = 1'b1;
        end
        else
        begin
            bus.result = (x ^ y) ^ c[3:0];
            bus.carry_out = c[4];
            bus.prop_n = ~(&p);
            bus.gen_n = ~(g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]));
        end
    end
endmodule

// ---- fbasa_top.sv ----
// Purpose: Four-bit accumulator slice, ALU feeding a shift and storage register
// Assumes: All pin inputs are asynchronous and pass the synchroniser
// Notes: Result and flag outputs are registered copies, one clock behind the internal loop; store_out is not registered
`timescale 1ns/1ps
// How it works
// - Sixteen operations from select and mode
// - Mode high gives logic, ignores carry
// - Carry high adds one in arithmetic, except code zero
// - Both subtraction orders are available
// - Code zero gives 1110 or 1111
// - Codes four to seven pass or invert
// - Logic codes give zero, XOR, AND, OR, NAND
// - Parallel carries, active-low propagate and generate
// - Register feeds B, loads ALU result
// - Two selects plus shift kind choose action
// - Load takes result, cascade lines released
// - Logical left takes top from high line
// - Arithmetic left keeps sign, feeds third stage
// - Logical right takes bottom from low line
// - Arithmetic right keeps sign, outputs third stage
// - Hold keeps stages, cascade lines released
// - Register changes only on clock edges
// - Cascade lines driven only when shifting out
// - Low line shifts right in, left out
module fbasa_top
    import fbasa_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic [3:0] operand_a_in,
    input wire logic [2:0] alu_func_sel_in,
    input wire logic logic_mode_in,
    input wire logic carry_in_in,
    input wire logic shift_kind_control_in,
    input wire logic [1:0] reg_sel_in,
    input wire logic low_end_cascade_io_in,
    input wire logic high_end_cascade_io_in,
    output logic low_end_cascade_io_out,
    output logic low_end_cascade_io_oe_out,
    output logic high_end_cascade_io_out,
    output logic high_end_cascade_io_oe_out,
    output logic [3:0] result_out,
    output logic carry_out,
    output logic prop_n_out,
    output logic gen_n_out,
    output logic [3:0] store_out
);
    logic [13:0] pins;
    logic [13:0] lvl;
    logic [3:0] s_a;
    logic [2:0] s_fsel;
    logic s_mode;
    logic s_cin;
    logic s_kind;
    logic [1:0] s_rsel;
    logic s_low;
    logic s_high;
    logic [3:0] store;
    logic [3:0] next_store;
    logic low_q;
    logic low_oe_q;
    logic high_q;
    logic high_oe_q;
    logic next_low;
    logic next_low_oe;
    logic next_high;
    logic next_high_oe;
    logic [3:0] result_q;
    logic cout_q;
    logic prop_n_q;
    logic gen_n_q;
    fbasa_alu_if alu_bus ();

    assign pins = {operand_a_in, alu_func_sel_in, logic_mode_in, carry_in_in, shift_kind_control_in,
        reg_sel_in, low_end_cascade_io_in, high_end_cascade_io_in};

    fbasa_sync #(.WIDTH(FBASA_SYNC_WIDTH)) u_sync
    (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .pins_in(pins),
        .level_out(lvl)
    );

    assign s_a = lvl[13:10];
    assign s_fsel = lvl[9:7];
    assign s_mode = lvl[6];
    assign s_cin = lvl[5];
    assign s_kind = lvl[4];
    assign s_rsel = lvl[3:2];
    assign s_low = lvl[1];
    assign s_high = lvl[0];

    assign alu_bus.operand_a = s_a;
    assign alu_bus.operand_b = store;
    assign alu_bus.func_sel = s_fsel;
    assign alu_bus.logic_mode = s_mode;
    assign alu_bus.carry_in = s_cin;

    fbasa_alu u_alu
    (
        .bus(alu_bus.alu)
    );

    // Stage a is bit 0, stage d is bit 3 and carries the sign
    always_comb
    begin
        next_store = store;
        next_low = low_q;
        next_high = high_q;
        next_low_oe = 1'b0;
        next_high_oe = 1'b0;
        unique case (s_rsel)
            FBASA_RSEL_LOAD:
            begin
                next_store = alu_bus.result;
            end
            FBASA_RSEL_LEFT:
            begin
                if (s_kind)
                begin
                    next_store = {store[3], s_high, store[2:1]};
                end
                else
                begin
                    next_store = {s_high, store[3:1]};
                end
                next_low = next_store[0];
                next_low_oe = 1'b1;
            end
            FBASA_RSEL_RIGHT:
            begin
                if (s_kind)
                begin
                    next_store = {store[3], store[1:0], s_low};
                    next_high = next_store[2];
                end
                else
                begin
                    next_store = {store[2:0], s_low};
                    next_high = next_store[3];
                end
                next_high_oe = 1'b1;
            end
            FBASA_RSEL_HOLD:
            begin
                next_store = store;
            end
        endcase
    end

    // No reset here: during reset the select reads as load, so code zero loads 1111
    always_ff @(posedge mclk_in)
    begin
        store <= next_store;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!resetn_in)
        begin
            low_q <= FBASA_BIT_RST;
            low_oe_q <= FBASA_BIT_RST;
            high_q <= FBASA_BIT_RST;
            high_oe_q <= FBASA_BIT_RST;
            result_q <= FBASA_OUT_RST;
            cout_q <= FBASA_BIT_RST;
            prop_n_q <= FBASA_NBIT_RST;
            gen_n_q <= FBASA_NBIT_RST;
        end
        else
        begin
            low_q <= next_low;
            low_oe_q <= next_low_oe;
            high_q <= next_high;
            high_oe_q <= next_high_oe;
            result_q <= alu_bus.result;
            cout_q <= alu_bus.carry_out;
            prop_n_q <= alu_bus.prop_n;
            gen_n_q <= alu_bus.gen_n;
        end
    end

    assign low_end_cascade_io_out = low_q;
    assign low_end_cascade_io_oe_out = low_oe_q;
    assign high_end_cascade_io_out = high_q;
    assign high_end_cascade_io_oe_out = high_oe_q;
    assign result_out = result_q;
    assign carry_out = cout_q;
    assign prop_n_out = prop_n_q;
    assign gen_n_out = gen_n_q;
    assign store_out = store;

    chk_load_takes_result: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LOAD) |=> (store == $past(alu_bus.result)) && !low_end_cascade_io_oe_out
        && !high_end_cascade_io_oe_out)
        else $error("load did not take ALU result");
    chk_hold_keeps_store: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_HOLD) |=> $stable(store) && !low_end_cascade_io_oe_out
        && !high_end_cascade_io_oe_out)
        else $error("hold changed store or drove a cascade line");
    chk_logical_left_shift: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LEFT && !s_kind) |=> (store == {$past(s_high), $past(store[3:1])})
        && low_end_cascade_io_oe_out && (low_end_cascade_io_out == store[0]))
        else $error("logical left shift wrong");
    chk_arith_left_sign: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LEFT && s_kind) |=> (store[3] == $past(store[3])) && (store[2] == $past(s_high))
        && (store[1:0] == $past(store[2:1])))
        else $error("arithmetic left shift wrong");
    chk_logical_right_shift: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_RIGHT && !s_kind) |=> (store == {$past(store[2:0]), $past(s_low)})
        && high_end_cascade_io_oe_out && (high_end_cascade_io_out == store[3]))
        else $error("logical right shift wrong");
    chk_arith_right_sign: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_RIGHT && s_kind) |=> (store[3] == $past(store[3]))
        && (high_end_cascade_io_out == store[2]) && !low_end_cascade_io_oe_out)
        else $error("arithmetic right shift wrong");
    chk_add_with_carry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_A_PLUS_B) |=> ({carry_out, result_out} ==
        5'({1'b0, $past(s_a)} + {1'b0, $past(store)} + {4'h0, $past(s_cin)})))
        else $error("add result wrong");
    chk_sub_a_minus_b: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_A_MINUS_B && s_cin) |=> (result_out == 4'($past(s_a) - $past(store))))
        else $error("A minus B wrong");
    chk_all_ones_code: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_ALL_ONES) |=> (result_out == ($past(s_cin) ? 4'he : 4'hf)))
        else $error("code zero arithmetic wrong");
    chk_logic_ignores_carry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_mode && s_fsel == FBASA_LG_NAND) |=> (result_out == ~($past(s_a) & $past(store))) && !carry_out)
        else $error("logic mode result wrong");

    // Cascade lines, the remaining codes and the look-ahead outputs
    chk_right_frees_low: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_RIGHT)
        |=> !low_end_cascade_io_oe_out && high_end_cascade_io_oe_out)
        else $error("right shift drove the low cascade line");
    chk_left_frees_high: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LEFT)
        |=> !high_end_cascade_io_oe_out && low_end_cascade_io_oe_out)
        else $error("left shift drove the high cascade line");
    chk_arith_left_out: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LEFT && s_kind)
        |=> low_end_cascade_io_oe_out && (low_end_cascade_io_out == store[0]))
        else $error("arithmetic left shift output wrong");
    chk_arith_right_body: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_RIGHT && s_kind)
        |=> (store[2:0] == {$past(store[1:0]), $past(s_low)}) && high_end_cascade_io_oe_out)
        else $error("arithmetic right shift body wrong");
    chk_lines_keep_value: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_rsel == FBASA_RSEL_LOAD || s_rsel == FBASA_RSEL_HOLD)
        |=> $stable(low_end_cascade_io_out) && $stable(high_end_cascade_io_out))
        else $error("released cascade value moved");
    chk_sub_b_minus_a: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_B_MINUS_A && s_cin)
        |=> (result_out == 4'($past(store) - $past(s_a))))
        else $error("B minus A wrong");
    chk_sub_no_carry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_A_MINUS_B && !s_cin)
        |=> (result_out == 4'($past(s_a) - $past(store) - 4'h1)))
        else $error("A minus B minus one wrong");
    chk_pass_b_code: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_PASS_B)
        |=> (result_out == 4'($past(store) + {3'h0, $past(s_cin)})))
        else $error("B code wrong");
    chk_not_b_code: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_NOT_B)
        |=> (result_out == 4'(~$past(store) + {3'h0, $past(s_cin)})))
        else $error("inverted B code wrong");
    chk_pass_a_code: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_PASS_A)
        |=> (result_out == 4'($past(s_a) + {3'h0, $past(s_cin)})))
        else $error("A code wrong");
    chk_not_a_code: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_fsel == FBASA_FN_NOT_A)
        |=> (result_out == 4'(~$past(s_a) + {3'h0, $past(s_cin)})))
        else $error("inverted A code wrong");
    chk_logic_zero: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_mode && s_fsel == FBASA_LG_ZERO)
        |=> (result_out == 4'h0))
        else $error("logic zero wrong");
    chk_logic_xor: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_mode && (s_fsel == FBASA_LG_XOR_A || s_fsel == FBASA_LG_XOR_B))
        |=> (result_out == ($past(s_a) ^ $past(store))))
        else $error("logic xor wrong");
    chk_logic_and: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_mode && (s_fsel == FBASA_LG_AND_A || s_fsel == FBASA_LG_AND_B))
        |=> (result_out == ($past(s_a) & $past(store))))
        else $error("logic and wrong");
    chk_logic_or: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (s_mode && (s_fsel == FBASA_LG_OR_A || s_fsel == FBASA_LG_OR_B))
        |=> (result_out == ($past(s_a) | $past(store))))
        else $error("logic or wrong");
    chk_logic_flags: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        s_mode
        |=> prop_n_out && gen_n_out && !carry_out)
        else $error("logic mode carry outputs active");
    chk_gen_sets_carry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !s_mode
        |=> (gen_n_out || carry_out))
        else $error("generate without carry out");
    chk_prop_passes_carry: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!s_mode && s_cin)
        |=> (prop_n_out || carry_out))
        else $error("propagate did not pass carry");
endmodule

// ---- fbasa_neighbour.sv ----
// Purpose: Neighbour slices seen on both cascade wires of the slice
// Assumes: The testbench decides when a neighbour drives its shift-in bit
// Notes: An undriven wire toggles each clock, so a floating level never reads as steady
`timescale 1ns/1ps
module fbasa_neighbour
(
    input wire logic mclk_in,
    input wire logic dut_low_oe_in,
    input wire logic dut_low_in,
    input wire logic dut_high_oe_in,
    input wire logic dut_high_in,
    input wire logic drive_low_in,
    input wire logic drive_high_in,
    input wire logic value_in,
    output logic low_wire_out,
    output logic high_wire_out
);
    logic float_bit = 1'b0;
    always @(posedge mclk_in)
        float_bit <= ~float_bit;
    // Two drivers on one wire give an unknown, which every later compare rejects
    always_comb
    begin
        low_wire_out = dut_low_oe_in ? dut_low_in : float_bit;
        if (drive_low_in)
            low_wire_out = dut_low_oe_in ? 1'bx : value_in;
        high_wire_out = dut_high_oe_in ? dut_high_in : ~float_bit;
        if (drive_high_in)
            high_wire_out = dut_high_oe_in ? 1'bx : value_in;
    end
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the accumulator slice
// Assumes: Pin changes reach the outputs five clocks later
// Notes: Store is preset by loading pass-A, which is stable under repeated loads
`timescale 1ns/1ps
module tb;
    import fbasa_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] a = 4'h0;
    logic [2:0] fsel = 3'h0;
    logic mode = 1'b0;
    logic cin = 1'b0;
    logic kind = 1'b0;
    logic [1:0] rsel = 2'h0;
    logic nb_lo_en = 1'b0;
    logic nb_hi_en = 1'b0;
    logic nb_val = 1'b0;
    logic lo_wire, hi_wire, lo_out, lo_oe, hi_out, hi_oe, cout, p_n, g_n;
    logic [3:0] res, store;
    int failures = 0;
    int compares = 0;

    always #5 mclk_in = ~mclk_in;

    fbasa_top i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .operand_a_in(a), .alu_func_sel_in(fsel),
        .logic_mode_in(mode), .carry_in_in(cin), .shift_kind_control_in(kind), .reg_sel_in(rsel),
        .low_end_cascade_io_in(lo_wire), .high_end_cascade_io_in(hi_wire), .low_end_cascade_io_out(lo_out),
        .low_end_cascade_io_oe_out(lo_oe), .high_end_cascade_io_out(hi_out), .high_end_cascade_io_oe_out(hi_oe),
        .result_out(res), .carry_out(cout), .prop_n_out(p_n), .gen_n_out(g_n), .store_out(store));
    fbasa_neighbour i_nb (.mclk_in(mclk_in), .dut_low_oe_in(lo_oe), .dut_low_in(lo_out), .dut_high_oe_in(hi_oe),
        .dut_high_in(hi_out), .drive_low_in(nb_lo_en), .drive_high_in(nb_hi_en), .value_in(nb_val),
        .low_wire_out(lo_wire), .high_wire_out(hi_wire));

    task automatic check(input string what, input logic [4:0] exp, input logic [4:0] seen);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    task automatic drive(input logic [1:0] rs, input logic k, input logic m, input logic [2:0] f,
        input logic c, input logic [3:0] av);
        rsel = rs;
        kind = k;
        mode = m;
        fsel = f;
        cin = c;
        a = av;
    endtask

    // Arithmetic is a sum of two chosen words; code zero uses the inverted carry
    // Bit 5 is the expected active-low propagate
    function automatic logic [5:0] alu_ref(input logic m, input logic [2:0] f, input logic c,
        input logic [3:0] x, input logic [3:0] y);
        logic [3:0] u;
        logic [3:0] v;
        if (m)
        begin
            case (f)
                3'h0: u = 4'h0;
                3'h1, 3'h2: u = x ^ y;
                3'h3, 3'h4: u = x & y;
                3'h6: u = ~(x & y);
                default: u = x | y;
            endcase
            return {2'h2, u};
        end
        case (f)
            3'h0: {u, v} = 8'hff;
            3'h1: {u, v} = {y, ~x};
            3'h2: {u, v} = {x, ~y};
            3'h3: {u, v} = {x, y};
            3'h4: {u, v} = {4'h0, y};
            3'h5: {u, v} = {4'h0, ~y};
            3'h6: {u, v} = {x, 4'h0};
            default: {u, v} = {4'h0, ~x};
        endcase
        return {~&(u | v), {1'b0, u} + {1'b0, v} + {4'h0, (f == 3'h0) ? ~c : c}};
    endfunction

    task automatic load(input logic [3:0] v);
        drive(FBASA_RSEL_LOAD, 1'b1, 1'b0, FBASA_FN_PASS_A, 1'b0, v);
        wait_n(6);
        check("loaded store", {1'b0, v}, {1'b0, store});
        check("lines released in load", 5'h00, {3'h0, lo_oe, hi_oe});
        drive(FBASA_RSEL_HOLD, 1'b0, 1'b0, FBASA_FN_PASS_A, 1'b0, v);
        wait_n(6);
    endtask

    task automatic alu_sweep(input logic m, input logic [3:0] av, input logic [3:0] bv);
        logic [5:0] exp;
        load(bv);
        for (int f = 0; f < 8; f++)
            for (int c = 0; c < 2; c++)
            begin
                drive(FBASA_RSEL_HOLD, c[0], m, 3'(f), c[0], av);
                wait_n(6);
                exp = alu_ref(m, 3'(f), c[0], av, bv);
                check("result and carry", exp[4:0], {cout, res});
                if (m || !c[0])
                    check("generate", {4'h0, m | ~exp[4]}, {4'h0, g_n});
                check("propagate", {4'h0, exp[5]}, {4'h0, p_n});
                check("store held", {1'b0, bv}, {1'b0, store});
            end
    endtask

    task automatic shift_test(input logic [1:0] rs, input logic k, input logic in_bit);
        logic [3:0] prev;
        logic [3:0] exp;
        logic left;
        left = (rs == FBASA_RSEL_LEFT);
        load(4'h9);
        nb_val = in_bit;
        nb_hi_en = left;
        nb_lo_en = ~left;
        drive(rs, k, 1'b0, FBASA_FN_PASS_A, 1'b0, 4'h9);
        wait_n(5);
        repeat (3)
        begin
            prev = store;
            wait_n(1);
            case ({left, k})
                2'b10: exp = {in_bit, prev[3:1]};
                2'b11: exp = {prev[3], in_bit, prev[2:1]};
                2'b00: exp = {prev[2:0], in_bit};
                default: exp = {prev[3], prev[1:0], in_bit};
            endcase
            check("shifted store", {1'b0, exp}, {1'b0, store});
            if (left)
                check("low line drive", {3'h0, 1'b1, exp[0]}, {3'h0, lo_oe, lo_out});
            else
                check("high line drive", {3'h0, 1'b1, k ? exp[2] : exp[3]}, {3'h0, hi_oe, hi_out});
            check("input line released", 5'h00, {4'h0, left ? hi_oe : lo_oe});
        end
        nb_hi_en = 1'b0;
        nb_lo_en = 1'b0;
    endtask

    task automatic hold_test();
        load(4'h6);
        drive(FBASA_RSEL_HOLD, 1'b1, 1'b0, FBASA_FN_NOT_A, 1'b1, 4'h1);
        wait_n(6);
        repeat (4)
        begin
            wait_n(1);
            check("held store", 5'h06, {1'b0, store});
            check("lines released in hold", 5'h00, {3'h0, lo_oe, hi_oe});
        end
    endtask

    initial
    begin
        wait_n(12);
        check("result in reset", 5'h00, {cout, res});
        check("flags in reset", 5'h0c, {1'b0, p_n, g_n, lo_oe, hi_oe});
        check("store after reset", 5'h0f, {1'b0, store});
        resetn_in = 1'b1;
        wait_n(2);
        alu_sweep(1'b0, 4'h3, 4'h5);
        alu_sweep(1'b0, 4'hc, 4'h6);
        alu_sweep(1'b1, 4'h3, 4'h5);
        alu_sweep(1'b1, 4'hc, 4'ha);
        shift_test(FBASA_RSEL_LEFT, 1'b0, 1'b0);
        shift_test(FBASA_RSEL_LEFT, 1'b1, 1'b1);
        shift_test(FBASA_RSEL_RIGHT, 1'b0, 1'b1);
        shift_test(FBASA_RSEL_RIGHT, 1'b1, 1'b0);
        hold_test();
        wrap_up();
    end

    // Guards against a hung run; normal runs finish far earlier
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        $display("Error run length expected done seen still running");
        wrap_up();
    end
endmodule
